/* File: hpp_pkg.sv */
package hpp_pkg;

    // Register offsets on the serial register interface
    localparam logic [7:0] HPP_PATH_CFG_ADDR    = 8'h18;
    localparam logic [7:0] HPP_THERMAL_CFG_ADDR = 8'h19;

    // Field positions in the path configuration register
    localparam int HPP_MODE_MSB = 7;
    localparam int HPP_MODE_LSB = 6;
    localparam int HPP_HYST_MSB = 5;
    localparam int HPP_HYST_LSB = 4;
    localparam int HPP_THR_MSB  = 3;
    localparam int HPP_THR_LSB  = 0;

    // Field positions in the thermal configuration register
    localparam int HPP_THM_INHIBIT_BIT = 6;
    localparam logic [7:0] HPP_THERMAL_CFG_MASK = 8'h7F;

    // Values after reset
    localparam logic [7:0] HPP_PATH_CFG_RESET    = 8'h00;
    localparam logic [7:0] HPP_THERMAL_CFG_RESET = 8'h00;

    // Threshold coding, millivolts
    localparam logic [12:0] HPP_THR_BASE_MV  = 13'h0FD2;
    localparam logic [12:0] HPP_THR_STEP_MV  = 13'h0032;
    localparam logic [3:0]  HPP_THR_MAX_CODE = 4'hB;

    // Hysteresis coding, millivolts
    localparam logic [12:0] HPP_HYST_BASE_MV = 13'h0046;
    localparam logic [12:0] HPP_HYST_STEP_MV = 13'h0032;

    typedef enum logic [1:0] {
        HPP_MODE_DIRECT    = 2'h0,
        HPP_MODE_THRESHOLD = 2'h1,
        HPP_MODE_DIODE     = 2'h2,
        HPP_MODE_RESERVED  = 2'h3
    } hpp_mode_type;

    typedef enum logic {
        HPP_PATH_DIRECT,
        HPP_PATH_DIODE
    } hpp_path_type;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hpp_reg_req_type;

    typedef struct packed {
        logic [7:0]   path_cfg;
        logic [7:0]   thermal_cfg;
        hpp_path_type path;
        logic [1:0]   chg_sync;
        logic [1:0]   en_sync;
        logic [7:0]   rdata;
        logic         direct_on;
        logic         diode_on;
        logic         active;
    } hpp_state_type;

endpackage

/* File: hpp_power_path_config.sv */
`timescale 1ns/100ps
// Summary of operation
// - Mode 00 forces the direct battery path with the pass transistor fully on, unless the thermal inhibit bit forces the ideal diode.
// - With thermal inhibit clear, mode 01 picks direct path below threshold, ideal diode above it.
// - In mode 01 the diode exit threshold drops by 70 to 220 mV.
// - Mode 10 runs the battery transistor permanently as an ideal diode.
// - Threshold code 0 is 4.05 V, 50 mV steps to 4.60 V; 1100 up reserved.
// - Path settings act only with charger supply absent and harvester enabled.
module hpp_power_path_config
    import hpp_pkg::*;
(
    input  wire logic            i_core_clk,
    input  wire logic            i_rst_b,
    input  wire hpp_reg_req_type i_reg_req,
    output logic [7:0]           o_reg_rdata,
    input  wire logic [12:0]     i_battery_mv,
    input  wire logic            i_charger_input_supply,
    input  wire logic            i_harvester_interaction_enable,
    output logic                 o_direct_path_on,
    output logic                 o_ideal_diode_on,
    output logic                 o_harvester_path_active,
    output logic [12:0]          o_threshold_mv,
    output logic                 o_threshold_reserved
);

    hpp_state_type s_q;
    hpp_state_type s_d;

    hpp_mode_type path_mode_select;
    logic [1:0]   recharge_hysteresis_select;
    logic [3:0]   battery_threshold_select;
    logic         thermal_inhibit_override;

    logic         mode_direct;
    logic         mode_threshold;
    logic         mode_diode;

    logic         thr_reserved;
    logic [3:0]   thr_code;
    logic [12:0]  thr_mv;
    logic [12:0]  hyst_mv;
    logic [12:0]  exit_mv;
    logic         above_thr;
    logic         below_exit;

    logic         charger_present;
    logic         harvester_enabled;
    logic         active;
    logic         wr_path_cfg;
    logic         wr_thermal_cfg;

    always_comb
    begin
        path_mode_select           = hpp_mode_type'(s_q.path_cfg[HPP_MODE_MSB:HPP_MODE_LSB]);
        recharge_hysteresis_select = s_q.path_cfg[HPP_HYST_MSB:HPP_HYST_LSB];
        battery_threshold_select   = s_q.path_cfg[HPP_THR_MSB:HPP_THR_LSB];
        thermal_inhibit_override   = s_q.thermal_cfg[HPP_THM_INHIBIT_BIT];
    end

    always_comb
    begin
        mode_direct    = 1'b0;
        mode_threshold = 1'b0;
        mode_diode     = 1'b0;
        case (path_mode_select)
            HPP_MODE_DIRECT:
            begin
                mode_direct = 1'b1;
            end
            HPP_MODE_THRESHOLD:
            begin
                mode_threshold = 1'b1;
            end
            HPP_MODE_DIODE:
            begin
                mode_diode = 1'b1;
            end
            default:
            begin
                // Mode 11 selects no path of its own
                mode_direct = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        thr_reserved = (battery_threshold_select > HPP_THR_MAX_CODE);
        // Reserved codes clamp to the top threshold
        if (thr_reserved)
        begin
            thr_code = HPP_THR_MAX_CODE;
        end
        else
        begin
            thr_code = battery_threshold_select;
        end
        thr_mv     = HPP_THR_BASE_MV + 13'(HPP_THR_STEP_MV * 13'(thr_code));
        hyst_mv    = HPP_HYST_BASE_MV
                     + 13'(HPP_HYST_STEP_MV * 13'(recharge_hysteresis_select));
        exit_mv    = thr_mv - hyst_mv;
        above_thr  = (i_battery_mv > thr_mv);
        below_exit = (i_battery_mv < exit_mv);
    end

    always_comb
    begin
        charger_present   = s_q.chg_sync[1];
        harvester_enabled = s_q.en_sync[1];
        active            = !charger_present && harvester_enabled;
        wr_path_cfg       = i_reg_req.wr_en && (i_reg_req.addr == HPP_PATH_CFG_ADDR);
        wr_thermal_cfg    = i_reg_req.wr_en && (i_reg_req.addr == HPP_THERMAL_CFG_ADDR);
    end

    always_comb
    begin
        s_d = s_q;

        // Two-stage synchronisers for the asynchronous supply and enable levels
        s_d.chg_sync = {s_q.chg_sync[0], i_charger_input_supply};
        s_d.en_sync  = {s_q.en_sync[0], i_harvester_interaction_enable};
        s_d.active   = active;

        // Writes to any other address are ignored
        if (wr_path_cfg)
        begin
            s_d.path_cfg = i_reg_req.wdata;
        end
        if (wr_thermal_cfg)
        begin
            s_d.thermal_cfg = i_reg_req.wdata & HPP_THERMAL_CFG_MASK;
        end

        // Read data follows the presented address one cycle later
        case (i_reg_req.addr)
            HPP_PATH_CFG_ADDR:
            begin
                s_d.rdata = s_q.path_cfg;
            end
            HPP_THERMAL_CFG_ADDR:
            begin
                s_d.rdata = s_q.thermal_cfg;
            end
            default:
            begin
                s_d.rdata = 8'h00;
            end
        endcase

        // Threshold-mode path choice; the exit point sits below the entry point
        case (s_q.path)
            HPP_PATH_DIRECT:
            begin
                if (above_thr)
                begin
                    s_d.path = HPP_PATH_DIODE;
                end
            end
            HPP_PATH_DIODE:
            begin
                if (below_exit)
                begin
                    s_d.path = HPP_PATH_DIRECT;
                end
            end
            default:
            begin
                s_d.path = HPP_PATH_DIRECT;
            end
        endcase
        if (!active || !mode_threshold)
        begin
            s_d.path = HPP_PATH_DIRECT;
        end

        // Outside harvester operation the path is left to the charger logic
        s_d.direct_on = 1'b0;
        s_d.diode_on  = 1'b0;
        if (active)
        begin
            if (thermal_inhibit_override)
            begin
                s_d.diode_on = 1'b1;
            end
            else if (mode_direct)
            begin
                s_d.direct_on = 1'b1;
            end
            else if (mode_threshold)
            begin
                s_d.direct_on = (s_d.path == HPP_PATH_DIRECT);
                s_d.diode_on  = (s_d.path == HPP_PATH_DIODE);
            end
            else if (mode_diode)
            begin
                s_d.diode_on = 1'b1;
            end
            else
            begin
                // Both switches stay open in mode 11
                s_d.direct_on = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            s_q             <= '0;
            s_q.path_cfg    <= HPP_PATH_CFG_RESET;
            s_q.thermal_cfg <= HPP_THERMAL_CFG_RESET;
            s_q.path        <= HPP_PATH_DIRECT;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_reg_rdata             = s_q.rdata;
    assign o_direct_path_on        = s_q.direct_on;
    assign o_ideal_diode_on        = s_q.diode_on;
    assign o_harvester_path_active = s_q.active;
    assign o_threshold_mv          = thr_mv;
    assign o_threshold_reserved    = thr_reserved;

endmodule

/* File: hpp_power_path_config_monitor.sv */
`timescale 1ns/100ps
module hpp_power_path_config_monitor
    import hpp_pkg::*;
(
    input wire logic            i_core_clk,
    input wire logic            i_rst_b,
    input wire hpp_reg_req_type i_reg_req,
    input wire logic [7:0]      o_reg_rdata,
    input wire logic [12:0]     i_battery_mv,
    input wire logic            i_charger_input_supply,
    input wire logic            i_harvester_interaction_enable,
    input wire logic            o_direct_path_on,
    input wire logic            o_ideal_diode_on,
    input wire logic            o_harvester_path_active,
    input wire logic [12:0]     o_threshold_mv,
    input wire logic            o_threshold_reserved
);
    logic [7:0]  cfg_q;
    logic [12:0] thr;
    logic [12:0] ext;
    logic [1:0]  st;
    logic        ok;
    logic        on;
    logic        m1;
    logic        th_q;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            cfg_q <= 8'h00;
        else if (i_reg_req.wr_en && i_reg_req.addr == 8'h18)
            cfg_q <= i_reg_req.wdata;
    end
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            th_q <= 1'b0;
        else if (i_reg_req.wr_en && i_reg_req.addr == 8'h19)
            th_q <= i_reg_req.wdata[6];
    end
    assign thr = 13'h0FD2 + 13'h0032 * ((cfg_q[3:0] > 4'hB) ? 13'h000B : 13'(cfg_q[3:0]));
    assign ext = thr - 13'h0046 - 13'h0032 * 13'(cfg_q[5:4]);
    assign ok  = !i_charger_input_supply && i_harvester_interaction_enable;
    assign on  = o_harvester_path_active;
    assign st  = {o_direct_path_on, o_ideal_diode_on};
    assign m1  = on && cfg_q[7:6] == 2'h1;
    property p_direct;
        on && $past(on) && !$past(th_q) && $past(cfg_q[7:6]) == 2'h0 |-> st == 2'h2;
    endproperty
    a_direct: assert property (p_direct) else $error("direct path not forced");
    property p_diode;
        on && $past(on) && $past(cfg_q[7:6]) == 2'h2 |-> st == 2'h1;
    endproperty
    a_diode: assert property (p_diode) else $error("diode path not forced");
    property p_enter;
        on && $past(m1) && $past(i_battery_mv) > $past(thr) |-> st == 2'h1;
    endproperty
    a_enter: assert property (p_enter) else $error("diode not entered");
    property p_leave;
        on && $past(m1) && !$past(th_q) && $past(i_battery_mv) < $past(ext) |-> st == 2'h2;
    endproperty
    a_leave: assert property (p_leave) else $error("diode not left");
    property p_hold;
        on && $past(m1) && $past(m1, 2) && $past(o_ideal_diode_on) && !$past(th_q)
            && !$past(th_q, 2) && $past(i_battery_mv) >= $past(ext) |-> st == 2'h1;
    endproperty
    a_hold: assert property (p_hold) else $error("diode left inside band");
    property p_thr;
        o_threshold_mv == thr && o_threshold_reserved == (cfg_q[3:0] > 4'hB);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold decode wrong");
    property p_active;
        $past(i_rst_b, 3) |-> on == $past(ok, 3) && (on || $past(on) || st == 2'h0);
    endproperty
    a_active: assert property (p_active) else $error("path active wrong");
endmodule
bind hpp_power_path_config hpp_power_path_config_monitor u_hpp_power_path_config_monitor (.*);

/* File: hpp_power_path_config_tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR %0t %h %h", $time, a, e); end end
module hpp_power_path_config_tb_top
    import hpp_pkg::*;
    ;
    logic            i_core_clk;
    logic            i_rst_b;
    hpp_reg_req_type i_reg_req;
    logic [7:0]      o_reg_rdata;
    logic [12:0]     i_battery_mv;
    logic            i_charger_input_supply;
    logic            i_harvester_interaction_enable;
    logic            o_direct_path_on;
    logic            o_ideal_diode_on;
    logic            o_harvester_path_active;
    logic [12:0]     o_threshold_mv;
    logic            o_threshold_reserved;
    int              fail_count;
    int              compares;
    int              cyc;
    int              c;
    hpp_power_path_config u_hpp_power_path_config (.*);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk) i_reg_req = '{1'b1, a, d};
        @(negedge i_core_clk) i_reg_req.wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_core_clk) i_reg_req.addr = a;
        @(negedge i_core_clk) `CHK(o_reg_rdata, e)
    endtask
    task automatic pth(input logic [1:0] e);
        repeat (3) @(negedge i_core_clk);
        `CHK({o_direct_path_on, o_ideal_diode_on}, e)
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            report_and_stop;
        end
    end
    initial
    begin
        i_rst_b = 1'b0;
        i_reg_req = '0;
        i_battery_mv = 13'h0F00;
        i_charger_input_supply = 1'b0;
        i_harvester_interaction_enable = 1'b0;
        repeat (6) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        rd(8'h18, 8'h00);
        wr(8'h19, 8'hBF);
        rd(8'h19, 8'h3F);
        for (c = 0; c < 16; c++)
        begin
            wr(8'h18, 8'(c));
            rd(8'h18, 8'(c));
            `CHK(o_threshold_mv, (c > 11) ? 13'h11F8 : 13'h0FD2 + 13'h0032 * 13'(c))
            `CHK(o_threshold_reserved, 1'(c > 11))
        end
        wr(8'h20, 8'hFF);
        rd(8'h18, 8'h0F);
        rd(8'h20, 8'h00);
        i_harvester_interaction_enable = 1'b1;
        wr(8'h18, 8'h00);
        pth(2'h2);
        `CHK(o_harvester_path_active, 1'b1)
        wr(8'h19, 8'h40);
        pth(2'h1);
        wr(8'h19, 8'h00);
        pth(2'h2);
        wr(8'h18, 8'h80);
        pth(2'h1);
        wr(8'h18, 8'hC0);
        pth(2'h0);
        for (c = 0; c < 4; c++)
        begin
            wr(8'h18, 8'h40 | 8'(c << 4));
            pth(2'h2);
            i_battery_mv = 13'h0FD3;
            pth(2'h1);
            i_battery_mv = 13'h0F8C - 13'h0032 * 13'(c);
            pth(2'h1);
            i_battery_mv = i_battery_mv - 13'h0001;
            pth(2'h2);
        end
        i_charger_input_supply = 1'b1;
        pth(2'h0);
        `CHK(o_harvester_path_active, 1'b0)
        report_and_stop;
    end
endmodule
